// *** fwl_pkg.sv ***
// package of opcodes, status bit positions and timing for the write-latch and status block
package fwl_pkg;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_VOL_EN = 8'h50;
    localparam logic [7:0] OP_RD_LOW = 8'h05;
    localparam logic [7:0] OP_RD_HIGH = 8'h35;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_WR_HIGH = 8'h31;
    localparam logic [7:0] OP_WR_CFG = 8'h11;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_ERASE = 8'h52;
    localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_RESET = 8'h99;
    // status bit positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_RP_LO = 7;
    localparam int BIT_RP_HI = 8;
    localparam int BIT_QE = 9;
    localparam int BIT_FAIL = 10;
    localparam int BIT_LB_LO = 11;
    localparam int BIT_CMP = 14;
    localparam int BIT_SUS = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // writable masks: bits a status write may touch
    localparam logic [7:0] WR_MASK_LOW = 8'hfc;
    localparam logic [7:0] WR_MASK_HIGH = 8'h7b;
    // self-timed cycles
    localparam int CLK_MHZ = 25;
    localparam int STAT_WR_US = 5;
    localparam int STAT_WR_CYC = STAT_WR_US * CLK_MHZ;
    localparam int OP_US = 20;
    localparam int OP_CYC = OP_US * CLK_MHZ;
endpackage : fwl_pkg

// *** fwl_link_if.sv ***
// interface carrying decoded serial frame events between front end and core
`timescale 1ns/1ps
`default_nettype none
interface fwl_link_if;
    logic byte_done;
    logic [7:0] byte_val;
    logic [5:0] byte_idx;
    logic frame_end;
    logic [5:0] frame_bytes;
    logic [2:0] bit_cnt;
    logic fall_edge;
    logic active;
    modport front (output byte_done, byte_val, byte_idx, frame_end,
                   frame_bytes, bit_cnt, fall_edge, active);
    modport core (input byte_done, byte_val, byte_idx, frame_end,
                  frame_bytes, bit_cnt, fall_edge, active);
endinterface : fwl_link_if
`default_nettype wire

// *** fwl_front.sv ***
// serial front end: syncs chip select and clock, assembles bytes
`timescale 1ns/1ps
`default_nettype none
module fwl_front (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    // decoded events
    fwl_link_if.front lk
);
    logic [1:0] sck_s;
    logic [1:0] cs_s;
    logic [1:0] si_s;
    logic sck_d;
    logic cs_d;
    logic [7:0] shift;
    wire rise = sck_s[1] & ~sck_d;
    wire fall = ~sck_s[1] & sck_d;
    wire sel = ~cs_s[1];
    wire [7:0] next_shift = {shift[6:0], si_s[1]};
    wire last_bit = lk.bit_cnt == 3'd7;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_s <= 2'h0;
            cs_s <= 2'h3;
            si_s <= 2'h0;
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sck_s <= {sck_s[0], sck};
            cs_s <= {cs_s[0], cs_n};
            si_s <= {si_s[0], si};
            sck_d <= sck_s[1];
            cs_d <= cs_s[1];
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift <= 8'h00;
            lk.bit_cnt <= 3'd0;
            lk.byte_done <= 1'b0;
            lk.byte_val <= 8'h00;
            lk.byte_idx <= 6'd0;
            lk.frame_bytes <= 6'd0;
            lk.frame_end <= 1'b0;
            lk.fall_edge <= 1'b0;
            lk.active <= 1'b0;
        end else begin
            lk.byte_done <= 1'b0;
            lk.fall_edge <= sel & fall;
            lk.frame_end <= cs_s[1] & ~cs_d;
            lk.active <= sel;
            if (!sel) begin
                // counts stay visible through the frame_end cycle so the
                // core can tell a clean eight-bit frame from a ragged one
                if (lk.frame_end) begin
                    lk.bit_cnt <= 3'd0;
                    lk.frame_bytes <= 6'd0;
                end
            end else if (rise) begin
                shift <= next_shift;
                lk.bit_cnt <= lk.bit_cnt + 3'd1;
                if (last_bit) begin
                    lk.byte_done <= 1'b1;
                    lk.byte_val <= next_shift;
                    lk.byte_idx <= lk.frame_bytes;
                    if (lk.frame_bytes != 6'h3f) begin
                        lk.frame_bytes <= lk.frame_bytes + 6'd1;
                    end
                end
            end
        end
    end
endmodule : fwl_front
`default_nettype wire

// *** fwl_status_regs.sv ***
// status register bank with write-enable latch, protect policy and busy timer
`timescale 1ns/1ps
`default_nettype none
module fwl_status_regs
    import fwl_pkg::*;
#(
    parameter int STAT_WR_CYCLES = fwl_pkg::STAT_WR_CYC,
    parameter int OP_CYCLES = fwl_pkg::OP_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // serial bus pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // protect pin, active low
    input wire logic wp_n,
    // array engine report
    input wire logic op_fail,
    input wire logic region_hit,
    // status view
    output logic [15:0] status,
    output logic quad_io_enable,
    output logic op_start,
    output logic chip_erase_start
);
    import fwl_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STAT_WR = 2'b01,
        ST_OP = 2'b10
    } fwl_busy_t;

    fwl_link_if lk ();
    fwl_front u_front (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .lk(lk)
    );

    logic [1:0] wp_s;
    logic [15:0] sreg;
    logic [7:0] opcode;
    logic [7:0] data0;
    logic [7:0] data1;
    logic vol_armed;
    logic vol_pending;
    logic [15:0] pend_val;
    logic [15:0] pend_mask;
    logic pend_vol;
    logic [7:0] tx;
    logic rd_on;
    logic [11:0] timer;
    logic op_is_chip;
    fwl_busy_t busy_st;

    wire write_enable_latch = sreg[BIT_WEL];
    wire busy = busy_st != ST_IDLE;
    wire [1:0] rp = {sreg[BIT_RP_HI], sreg[BIT_RP_LO]};
    wire [4:0] bp = sreg[BIT_BP_LO +: 5];
    // lock policy from the register-protect pair and the synced pin
    wire hw_locked = (rp == 2'b01 && !wp_s[1]) || rp[1];
    wire bp_open = bp == 5'h00;
    wire one_byte = lk.frame_bytes == 6'd1;
    wire exact_op = lk.frame_end && one_byte && lk.bit_cnt == 3'd0;
    wire is_wr_low = opcode == OP_WR_STAT;
    wire is_wr_high = opcode == OP_WR_HIGH;
    wire wr_frame = lk.frame_end && lk.bit_cnt == 3'd0 &&
        ((is_wr_low && (lk.frame_bytes == 6'd2 || lk.frame_bytes == 6'd3))
        || (is_wr_high && lk.frame_bytes == 6'd2));
    // volatile write needs no latch, non-volatile needs it
    wire wr_allowed = (write_enable_latch || vol_armed) && !hw_locked && !busy;
    wire is_prog = opcode == OP_PAGE_PROG || opcode == OP_PAGE_ERASE ||
        opcode == OP_SECT_ERASE || opcode == OP_HALF_ERASE ||
        opcode == OP_BLK_ERASE;
    wire is_chip = opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B;
    wire prog_frame = lk.frame_end && lk.bit_cnt == 3'd0 &&
        ((is_prog && lk.frame_bytes >= 6'd4) || (is_chip && one_byte));
    wire prog_go = prog_frame && write_enable_latch && !busy &&
        !(is_prog && region_hit) && !(is_chip && !bp_open);
    wire prog_blocked = prog_frame && write_enable_latch && !busy && !prog_go;
    wire [15:0] wr_val = is_wr_high ? {data0, 8'h00} :
        (lk.frame_bytes == 6'd3 ? {data1, data0} : {8'h00, data0});
    wire [15:0] wr_mask_raw = is_wr_high ? {WR_MASK_HIGH, 8'h00} :
        (lk.frame_bytes == 6'd3 ? {WR_MASK_HIGH, WR_MASK_LOW} :
        {8'h00, WR_MASK_LOW});
    // security lock bits can only be raised by or-ing them in
    wire [15:0] lock_keep = 16'h0007 << BIT_LB_LO;
    wire [15:0] next_sreg_wr = (sreg & ~pend_mask) | (pend_val & pend_mask &
        ~lock_keep) | (sreg & lock_keep) | (pend_val & pend_mask & lock_keep);
    wire timer_done = timer == 12'd1;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_s <= 2'h3;
        end else begin
            wp_s <= {wp_s[0], wp_n};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            opcode <= 8'h00;
            data0 <= 8'h00;
            data1 <= 8'h00;
        end else if (lk.byte_done) begin
            if (lk.byte_idx == 6'd0) begin
                opcode <= lk.byte_val;
            end else if (lk.byte_idx == 6'd1) begin
                data0 <= lk.byte_val;
            end else if (lk.byte_idx == 6'd2) begin
                data1 <= lk.byte_val;
            end
        end
    end

    // volatile arm lasts only for the very next frame
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            vol_armed <= 1'b0;
        end else if (lk.frame_end) begin
            vol_armed <= exact_op && opcode == OP_VOL_EN;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_st <= ST_IDLE;
            timer <= 12'd0;
            pend_val <= 16'h0000;
            pend_mask <= 16'h0000;
            pend_vol <= 1'b0;
            op_is_chip <= 1'b0;
            vol_pending <= 1'b0;
        end else begin
            unique case (busy_st)
                ST_IDLE: begin
                    if (wr_frame && wr_allowed) begin
                        pend_val <= wr_val;
                        // raw write mask taken; block-protect bits not held back
                        pend_mask <= wr_mask_raw;
                        pend_vol <= vol_armed;
                        if (vol_armed) begin
                            vol_pending <= 1'b1;
                        end else begin
                            busy_st <= ST_STAT_WR;
                            timer <= 12'(STAT_WR_CYCLES);
                        end
                    end else if (prog_go) begin
                        busy_st <= ST_OP;
                        timer <= 12'(OP_CYCLES);
                        op_is_chip <= is_chip;
                    end
                    if (vol_pending) begin
                        vol_pending <= 1'b0;
                    end
                end
                ST_STAT_WR, ST_OP: begin
                    timer <= timer - 12'd1;
                    if (timer_done) begin
                        busy_st <= ST_IDLE;
                    end
                end
                default: busy_st <= ST_IDLE;
            endcase
        end
    end

    wire stat_wr_end = busy_st == ST_STAT_WR && timer_done;
    wire op_end = busy_st == ST_OP && timer_done;
    wire single_set = exact_op && opcode == OP_LATCH_SET;
    wire single_clr = exact_op && (opcode == OP_LATCH_CLR ||
        opcode == OP_SUSPEND || opcode == OP_RESET);
    wire [15:0] next_sreg = (stat_wr_end || vol_pending) ? next_sreg_wr : sreg;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sreg <= STATUS_RESET;
        end else begin
            // read-only bits are never taken from a status write
            sreg <= next_sreg;
            sreg[BIT_BUSY] <= busy_st != ST_IDLE && !timer_done;
            if (single_set) begin
                sreg[BIT_WEL] <= 1'b1;
            end else if (single_clr || stat_wr_end || op_end) begin
                sreg[BIT_WEL] <= 1'b0;
            end else if (vol_pending) begin
                sreg[BIT_WEL] <= sreg[BIT_WEL];
            end
            if (prog_blocked || (op_end && op_fail)) begin
                sreg[BIT_FAIL] <= 1'b1;
            end else if (op_end) begin
                sreg[BIT_FAIL] <= 1'b0;
            end
            if (exact_op && opcode == OP_SUSPEND && busy) begin
                sreg[BIT_SUS] <= 1'b1;
            end else if (exact_op && opcode == OP_RESUME) begin
                sreg[BIT_SUS] <= 1'b0;
            end
        end
    end

    // read shifter: loads after the opcode byte, shifts on clock falls
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx <= 8'h00;
            rd_on <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            if (!lk.active) begin
                rd_on <= 1'b0;
                so_oe <= 1'b0;
            end else if (lk.byte_done && lk.byte_idx == 6'd0 &&
                (lk.byte_val == OP_RD_LOW || lk.byte_val == OP_RD_HIGH)) begin
                rd_on <= 1'b1;
                tx <= lk.byte_val == OP_RD_HIGH ? sreg[15:8] : sreg[7:0];
            end else if (rd_on && lk.fall_edge) begin
                so <= tx[7];
                so_oe <= 1'b1;
                tx <= {tx[6:0], tx[7]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status <= STATUS_RESET;
            quad_io_enable <= 1'b0;
            op_start <= 1'b0;
            chip_erase_start <= 1'b0;
        end else begin
            status <= sreg;
            quad_io_enable <= sreg[BIT_QE];
            op_start <= prog_go && !is_chip;
            chip_erase_start <= prog_go && is_chip;
        end
    end

    wire [1:0] lb_unused = {op_is_chip, pend_vol};

    chk_latch_set_timing: assert property (@(posedge sys_clk) disable iff (!arst_n)
        single_set |=> sreg[BIT_WEL]) else $error("latch not set");
    chk_latch_clear_cmd: assert property (@(posedge sys_clk) disable iff (!arst_n)
        exact_op && opcode == OP_LATCH_CLR |=> !sreg[BIT_WEL])
        else $error("latch not cleared");
    chk_vol_no_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
        exact_op && opcode == OP_VOL_EN && !sreg[BIT_WEL] |=> !sreg[BIT_WEL])
        else $error("volatile enable set latch");
    chk_write_needs_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
        prog_frame && !write_enable_latch |=> busy_st == ST_IDLE)
        else $error("operation without latch");
    chk_chip_erase_guard: assert property (@(posedge sys_clk) disable iff (!arst_n)
        prog_go && is_chip |-> bp_open) else $error("chip erase while protected");
    chk_lock_policy: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_frame && hw_locked |=> busy_st != ST_STAT_WR)
        else $error("locked status written");
    chk_busy_stat_wr: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(busy_st == ST_STAT_WR) |=> sreg[BIT_BUSY] [*2])
        else $error("busy not shown");
    chk_wr_end_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
        stat_wr_end && !single_set |=> !sreg[BIT_WEL] && !sreg[BIT_BUSY])
        else $error("write end state wrong");
    chk_lock_sticky: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(sreg[BIT_LB_LO]) |-> sreg[BIT_LB_LO])
        else $error("security lock cleared");
    chk_fail_on_block: assert property (@(posedge sys_clk) disable iff (!arst_n)
        prog_blocked |=> sreg[BIT_FAIL]) else $error("fail flag missed");
    chk_cmp_region: assert property (@(posedge sys_clk) disable iff (!arst_n)
        prog_go && is_prog |-> !region_hit) else $error("protected region hit");
endmodule : fwl_status_regs
`default_nettype wire

// *** fwl_host_model.sv ***
// host controller model that frames commands on the serial flash pins
`timescale 1ns/1ps
`default_nettype none
module fwl_host_model (
    // serial pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    logic [7:0] rd_byte;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        rd_byte = 8'h00;
    end
    // n bits of wr go out msb first, then rd bits are taken on each rise;
    // the clock stands low outside frames
    task automatic frame(input int n, input logic [31:0] wr, input int rd);
        cs_n = 1'b0;
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            si = wr[i];
            #160 sck = 1'b1;
            #160 sck = 1'b0;
        end
        // data line no longer held: show the inverse, not the stale bit
        si = ~si;
        for (int i = 0; i < rd; i++) begin
            #160 sck = 1'b1;
            rd_byte = {rd_byte[6:0], so};
            #160 sck = 1'b0;
        end
        #160 cs_n = 1'b1;
        #480;
    endtask : frame
endmodule : fwl_host_model
`default_nettype wire

// *** fwl_status_regs_tb.sv ***
// self-checking bench for the write latch and status register block
`timescale 1ns/1ps
`default_nettype none
module fwl_status_regs_tb;
    import fwl_pkg::*;
    logic sys_clk, arst_n, wp_n, op_fail, region_hit;
    wire sck, cs_n, si, so, so_oe, quad_io_enable, op_start, chip_erase_start;
    wire [15:0] status;
    logic [15:0] exp_st, d;
    logic [7:0] rb;
    int err_count = 0, samples_checked = 0, n_op = 0, n_ce = 0, k, mode, c;
    logic [7:0] ops [4] = '{OP_PAGE_ERASE, OP_SECT_ERASE, OP_HALF_ERASE,
                            OP_BLK_ERASE};

    fwl_host_model u_fwl_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    fwl_status_regs #(.STAT_WR_CYCLES(300), .OP_CYCLES(400)) u_fwl_status_regs (
        .sys_clk(sys_clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .wp_n(wp_n), .op_fail(op_fail),
        .region_hit(region_hit), .status(status),
        .quad_io_enable(quad_io_enable), .op_start(op_start),
        .chip_erase_start(chip_erase_start));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_op <= n_op + int'(op_start === 1'b1);
        n_ce <= n_ce + int'(chip_erase_start === 1'b1);
    end

    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // lock bits only ever gain ones; read-only bits are outside the masks
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] v);
        logic [15:0] m;
        m = {WR_MASK_HIGH, WR_MASK_LOW};
        merge = (o & ~m) | (v & m);
        merge[13:11] = o[13:11] | v[13:11];
    endfunction : merge
    task automatic cmd(input logic [7:0] op);
        u_fwl_host_model.frame(8, {24'h0, op}, 0);
    endtask : cmd
    task automatic rd(input logic [7:0] op);
        u_fwl_host_model.frame(8, {24'h0, op}, 8);
        rb = u_fwl_host_model.rd_byte;
    endtask : rd
    task automatic wr(input logic [7:0] en, input logic [15:0] v);
        if (en != 8'h00) cmd(en);
        u_fwl_host_model.frame(24, {8'h0, OP_WR_STAT, v[7:0], v[15:8]}, 0);
    endtask : wr
    task automatic idle;
        for (k = 0; k < 2000 && status[0] !== 1'b0; k++) @(posedge sys_clk);
        if (k == 2000) begin
            err_count++;
            close_out;
        end
        #1;
    endtask : idle
    task automatic rd_all;
        rd(OP_RD_LOW);
        chk("low byte", {8'h0, exp_st[7:0]}, {8'h0, rb});
        rd(OP_RD_HIGH);
        chk("high byte", {8'h0, exp_st[15:8]}, {8'h0, rb});
        chk("status", exp_st, status);
        chk("so released", 16'h0, {15'h0, so_oe});
    endtask : rd_all

    initial begin
        #3000000;
        err_count++;
        close_out;
    end
    initial begin
        arst_n = 1'b0;
        wp_n = 1'b1;
        op_fail = 1'b0;
        region_hit = 1'b0;
        exp_st = STATUS_RESET;
        void'($urandom(32'h029d));
        repeat (12) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        rd_all;
        cmd(OP_LATCH_SET);
        exp_st[1] = 1'b1;
        rd_all;
        u_fwl_host_model.frame(9, {23'h0, OP_LATCH_CLR, 1'b0}, 0);
        chk("latch after 9 bits", 16'h1, {15'h0, status[1]});
        cmd(OP_LATCH_CLR);
        chk("latch cleared", 16'h0, {15'h0, status[1]});
        u_fwl_host_model.frame(7, {25'h0, OP_LATCH_SET[7:1]}, 0);
        chk("latch after 7 bits", 16'h0, {15'h0, status[1]});
        cmd(OP_VOL_EN);
        chk("latch after arm", 16'h0, {15'h0, status[1]});
        exp_st[1] = 1'b0;
        // random status writes: volatile, latched, or without any enable
        for (int i = 0; i < 6; i++) begin
            mode = $urandom_range(2);
            d = 16'($urandom) & 16'hfe7f;
            if (mode == 0) begin
                wr(OP_VOL_EN, d);
                exp_st = merge(exp_st, d);
            end else if (mode == 1) begin
                wr(OP_LATCH_SET, d);
                chk("busy in write", 16'h1, {15'h0, status[0]});
                rd(OP_RD_LOW);
                chk("busy read", 16'h1, {15'h0, rb[0]});
                idle;
                exp_st = merge(exp_st, d);
            end else begin
                wr(8'h00, d);
            end
            rd_all;
            chk("quad", {15'h0, exp_st[9]}, {15'h0, quad_io_enable});
        end
        // chip erase with a protected setting, then with none
        exp_st = merge(exp_st, {exp_st[15:8], 8'h04});
        wr(OP_VOL_EN, exp_st);
        c = n_ce;
        cmd(OP_LATCH_SET);
        cmd(OP_CHIP_ERASE_A);
        chk("erase refused", 16'(c), 16'(n_ce));
        chk("fail set", 16'h1, {15'h0, status[10]});
        exp_st = merge(exp_st, {exp_st[15:8], 8'h00});
        wr(OP_VOL_EN, exp_st);
        cmd(OP_LATCH_SET);
        cmd(OP_CHIP_ERASE_B);
        chk("erase run", 16'(c + 1), 16'(n_ce));
        idle;
        chk("fail cleared", 16'h0, {14'h0, status[10], status[1]});
        foreach (ops[i]) begin
            op_fail = 1'($urandom_range(1));
            c = n_op;
            cmd(OP_LATCH_SET);
            u_fwl_host_model.frame(32, {ops[i], 24'($urandom)}, 0);
            chk("op start", 16'(c + 1), 16'(n_op));
            rd(OP_RD_LOW);
            chk("busy op", 16'h1, {15'h0, rb[0]});
            idle;
            chk("op end", {op_fail, 1'b0}, {status[10], status[1]});
        end
        c = n_op;
        u_fwl_host_model.frame(32, {OP_SECT_ERASE, 24'h0}, 0);
        chk("no latch", 16'(c), 16'(n_op));
        region_hit = 1'b1;
        cmd(OP_LATCH_SET);
        u_fwl_host_model.frame(32, {OP_SECT_ERASE, 24'h0}, 0);
        chk("protected", 16'(c), 16'(n_op));
        chk("fail prot", 16'h1, {15'h0, status[10]});
        region_hit = 1'b0;
        exp_st[10] = 1'b1;
        // protect policy: hardware lock, then lock-down until power cycle
        d = {exp_st[15:8], 8'h80};
        wr(OP_LATCH_SET, d);
        idle;
        exp_st = merge(exp_st, d);
        wp_n = 1'b0;
        wr(OP_LATCH_SET, {exp_st[15:8], 8'h84});
        chk("hw locked", exp_st & 16'hfffc, status & 16'hfffc);
        wp_n = 1'b1;
        d = {exp_st[15:9], 1'b1, 8'h00};
        wr(OP_VOL_EN, d);
        exp_st = merge(exp_st, d);
        chk("hw open", exp_st & 16'hfffc, status & 16'hfffc);
        wr(OP_VOL_EN, {exp_st[15:9], 1'b0, 8'h00});
        chk("lock-down", exp_st & 16'hfffc, status & 16'hfffc);
        arst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("power cycle", 16'h0, status);
        close_out;
    end
endmodule : fwl_status_regs_tb
`default_nettype wire
